// File: core/mfr_pkg.sv
package mfr_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_BANK = 8'h04;
	localparam logic [7:0] OFF_OPTION = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam int CFG_QUAD_BIT = 1;
	localparam int CFG_LC_LSB = 6;
	localparam int BANK_EXT_BIT = 7;
	localparam int OPT_ENH_BIT = 0;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic OPTION_RST = 1'b0;

	// ==========================================
	// instructions and frame lengths
	localparam logic [7:0] CMD_QUAD_RD = 8'h6B;
	localparam logic [7:0] CMD_QUAD_RD_WIDE = 8'h6C;
	localparam logic [7:0] CMD_DUAL_RD = 8'hBB;
	localparam logic [7:0] CMD_DUAL_RD_WIDE = 8'hBC;
	localparam logic [3:0] MODE_KEEP = 4'hA;
	localparam logic [5:0] INSTR_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
	localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
	localparam logic [5:0] MODE_BITS = 6'h08;
	localparam logic [3:0] SHORT_FRAME = 4'h8;
	localparam int DUMMY_W = 5;

	// ==========================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INSTR,
		ST_ADDR,
		ST_MODE,
		ST_WAIT,
		ST_DATA,
		ST_SKIP
	} mfr_state_type;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic [3:0] io;
	} mfr_pins_type;

	localparam mfr_pins_type PINS_RST = '{cs_n: 1'b1, sck: 1'b0, io: 4'hF};
endpackage

// File: core/mfr_read_engine.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module mfr_read_engine #(
	parameter int ADDR_W = 25,
	// five bits per entry, indexed by {table option, latency code}
	parameter logic [39:0] QUAD_DUMMY_MAP = 40'h42_1084_2108,
	parameter logic [39:0] DUAL_DUMMY_MAP = 40'h42_1084_2108
) (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial flash pins
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	// array read port
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_rdata
);
	// ==========================================
	// helpers
	function automatic logic [2:0] decode(input logic [7:0] op);
		case (op)
			mfr_pkg::CMD_QUAD_RD: return 3'b100;
			mfr_pkg::CMD_QUAD_RD_WIDE: return 3'b101;
			mfr_pkg::CMD_DUAL_RD: return 3'b110;
			mfr_pkg::CMD_DUAL_RD_WIDE: return 3'b111;
			default: return 3'b000;
		endcase
	endfunction

	function automatic logic [4:0] dummy_of(input logic [39:0] map, input logic [2:0] idx);
		return map[int'(idx) * mfr_pkg::DUMMY_W +: mfr_pkg::DUMMY_W];
	endfunction

	function automatic logic addr_hit(input logic [7:0] a);
		return a == mfr_pkg::OFF_CONFIG || a == mfr_pkg::OFF_BANK ||
			a == mfr_pkg::OFF_OPTION || a == mfr_pkg::OFF_STATUS;
	endfunction

	// ==========================================
	// pin synchronisers
	// three stages cost about 3 clk of lag per edge, which is why SCK must stay
	// well below the system clock
	mfr_pkg::mfr_pins_type s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [5:0] agree;
	logic sck_rise, sck_fall, cs_rise, cs_fall;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= mfr_pkg::PINS_RST;
			s2_reg <= mfr_pkg::PINS_RST;
			s3_reg <= mfr_pkg::PINS_RST;
			lvl_reg <= mfr_pkg::PINS_RST;
		end else begin
			s1_reg <= '{cs_n: spi_cs_n, sck: spi_sck, io: io_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= mfr_pkg::mfr_pins_type'((lvl_reg & ~agree) | (s3_reg & agree));
		end
	end

	assign agree = ~(s2_reg ^ s3_reg);
	assign sck_rise = agree[4] & s3_reg.sck & ~lvl_reg.sck;
	assign sck_fall = agree[4] & ~s3_reg.sck & lvl_reg.sck;
	assign cs_rise = agree[5] & s3_reg.cs_n & ~lvl_reg.cs_n;
	assign cs_fall = agree[5] & ~s3_reg.cs_n & lvl_reg.cs_n;

	// ==========================================
	// configuration registers
	logic [7:0] cfg_reg, bank_reg;
	logic enh_reg, wr_go, quad_en;

	assign wr_go = psel & penable & pready & pwrite;
	assign quad_en = cfg_reg[mfr_pkg::CFG_QUAD_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= mfr_pkg::CONFIG_RST;
			bank_reg <= mfr_pkg::BANK_RST;
			enh_reg <= mfr_pkg::OPTION_RST;
		end else if (wr_go) begin
			case (paddr)
				mfr_pkg::OFF_CONFIG: cfg_reg <= pwdata[7:0];
				mfr_pkg::OFF_BANK: bank_reg <= pwdata[7:0];
				mfr_pkg::OFF_OPTION: enh_reg <= pwdata[mfr_pkg::OPT_ENH_BIT];
				default: ;
			endcase
		end
	end

	// ==========================================
	// command sequencer
	mfr_pkg::mfr_state_type st_reg;
	logic [5:0] cnt_reg, step;
	logic [31:0] sh_reg, sh_next, full_addr;
	logic [4:0] wait_reg, dummy_sel;
	logic [3:0] rise_reg;
	logic dual_reg, wide_reg, mode_seen_reg, mode_ok_reg, cont_reg, cont_wide_reg;
	logic [7:0] op;
	logic [2:0] dec;
	logic instr_last, addr_done, mode_done;

	assign op = {sh_reg[6:0], s3_reg.io[0]};
	assign dec = decode(op);
	assign step = dual_reg ? 6'h02 : 6'h01;
	// dual reads land address and mode bits two per rise on IO1/IO0; quad reads take one per rise on IO0
	assign sh_next = dual_reg ? {sh_reg[29:0], s3_reg.io[1:0]} : {sh_reg[30:0], s3_reg.io[0]};
	// narrow addresses borrow the bank bits above A23
	assign full_addr = wide_reg ? sh_next : {1'b0, bank_reg[6:0], sh_next[23:0]};
	assign dummy_sel = dummy_of(dual_reg ? DUAL_DUMMY_MAP : QUAD_DUMMY_MAP,
		{enh_reg, cfg_reg[mfr_pkg::CFG_LC_LSB +: 2]});
	assign instr_last = sck_rise && st_reg == mfr_pkg::ST_INSTR && cnt_reg == 6'h01;
	assign addr_done = sck_rise && st_reg == mfr_pkg::ST_ADDR && cnt_reg == step;
	assign mode_done = sck_rise && st_reg == mfr_pkg::ST_MODE && cnt_reg == 6'h02;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= mfr_pkg::ST_IDLE;
			cnt_reg <= 6'h00;
			sh_reg <= 32'h0000_0000;
			wait_reg <= 5'h00;
			rise_reg <= 4'h0;
			dual_reg <= 1'b0;
			wide_reg <= 1'b0;
			mode_seen_reg <= 1'b0;
			mode_ok_reg <= 1'b0;
		end else if (cs_rise) begin
			st_reg <= mfr_pkg::ST_IDLE;
		end else if (cs_fall) begin
			sh_reg <= 32'h0000_0000;
			rise_reg <= 4'h0;
			mode_seen_reg <= 1'b0;
			if (cont_reg) begin
				st_reg <= mfr_pkg::ST_ADDR;
				dual_reg <= 1'b1;
				wide_reg <= cont_wide_reg;
				cnt_reg <= cont_wide_reg ? mfr_pkg::ADDR_BITS_WIDE : mfr_pkg::ADDR_BITS_NARROW;
			end else begin
				st_reg <= mfr_pkg::ST_INSTR;
				dual_reg <= 1'b0;
				cnt_reg <= mfr_pkg::INSTR_BITS;
			end
		end else if (sck_rise) begin
			if (rise_reg != 4'hF) begin
				rise_reg <= rise_reg + 4'h1;
			end
			unique case (st_reg)
				mfr_pkg::ST_INSTR: begin
					sh_reg <= {sh_reg[30:0], s3_reg.io[0]};
					cnt_reg <= cnt_reg - 6'h01;
					if (cnt_reg == 6'h01) begin
						// four-lane read needs the quad enable bit
						if (dec[2] && (dec[1] || quad_en)) begin
							st_reg <= mfr_pkg::ST_ADDR;
							dual_reg <= dec[1];
							wide_reg <= dec[0] | bank_reg[mfr_pkg::BANK_EXT_BIT];
							cnt_reg <= (dec[0] | bank_reg[mfr_pkg::BANK_EXT_BIT]) ?
								mfr_pkg::ADDR_BITS_WIDE : mfr_pkg::ADDR_BITS_NARROW;
						end else begin
							st_reg <= mfr_pkg::ST_SKIP;
						end
					end
				end
				mfr_pkg::ST_ADDR: begin
					sh_reg <= sh_next;
					cnt_reg <= cnt_reg - step;
					if (cnt_reg == step) begin
						if (dual_reg && enh_reg) begin
							st_reg <= mfr_pkg::ST_MODE;
							cnt_reg <= mfr_pkg::MODE_BITS;
						end else begin
							st_reg <= mfr_pkg::ST_WAIT;
							wait_reg <= dummy_sel;
						end
					end
				end
				mfr_pkg::ST_MODE: begin
					sh_reg <= sh_next;
					cnt_reg <= cnt_reg - 6'h02;
					if (cnt_reg == 6'h02) begin
						mode_seen_reg <= 1'b1;
						mode_ok_reg <= sh_next[7:4] == mfr_pkg::MODE_KEEP;
						st_reg <= mfr_pkg::ST_WAIT;
						wait_reg <= dummy_sel;
					end
				end
				mfr_pkg::ST_IDLE, mfr_pkg::ST_WAIT, mfr_pkg::ST_DATA, mfr_pkg::ST_SKIP: ;
				default: st_reg <= mfr_pkg::ST_SKIP;
			endcase
		end else if (sck_fall && st_reg == mfr_pkg::ST_WAIT) begin
			// lines are not looked at here; dummies count fall to fall
			if (wait_reg == 5'h00) begin
				st_reg <= mfr_pkg::ST_DATA;
			end else begin
				wait_reg <= wait_reg - 5'h01;
			end
		end
	end

	// ==========================================
	// continuous mode
	// a select rise in mode cycles, or in dummy cycles with no mode phase, keeps the old state;
	// once the mode byte is in, a rise applies it: the outcome is undefined for the host anyway
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cont_reg <= 1'b0;
			cont_wide_reg <= 1'b0;
		end else if (cs_rise) begin
			if (mode_seen_reg) begin
				cont_reg <= mode_ok_reg;
				cont_wide_reg <= wide_reg;
			end else if (rise_reg <= mfr_pkg::SHORT_FRAME) begin
				cont_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// data out and address counter
	logic [7:0] byte_reg, src;
	logic [1:0] slot_reg;
	logic data_fall, last_slot;

	assign data_fall = sck_fall && !cs_rise && (st_reg == mfr_pkg::ST_DATA ||
		(st_reg == mfr_pkg::ST_WAIT && wait_reg == 5'h00));
	assign src = (slot_reg == 2'h0) ? mem_rdata : byte_reg;
	assign last_slot = dual_reg ? slot_reg == 2'h3 : slot_reg == 2'h1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_out <= 4'h0;
			io_oe_n <= 4'hF;
			byte_reg <= 8'h00;
			slot_reg <= 2'h0;
		end else if (cs_rise || cs_fall) begin
			io_oe_n <= 4'hF;
			slot_reg <= 2'h0;
		end else if (data_fall) begin
			slot_reg <= last_slot ? 2'h0 : slot_reg + 2'h1;
			if (dual_reg) begin
				io_out <= {2'b00, src[7:6]};
				io_oe_n <= 4'b1100;
				byte_reg <= {src[5:0], 2'b00};
			end else begin
				io_out <= src[7:4];
				io_oe_n <= 4'h0;
				byte_reg <= {src[3:0], 4'h0};
			end
		end
	end

	// the array port needs a full byte ahead: the read for byte n+1 starts as byte n
	// is latched, so the array has a whole byte time to answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr <= '0;
		end else if (addr_done && !cs_rise) begin
			mem_addr <= full_addr[ADDR_W-1:0];
		end else if (data_fall && slot_reg == 2'h0) begin
			mem_addr <= mem_addr + 1'b1;
		end
	end

	// ==========================================
	// bus slave
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				pslverr <= !addr_hit(paddr);
				case (paddr)
					mfr_pkg::OFF_CONFIG: prdata <= {24'h00_0000, cfg_reg};
					mfr_pkg::OFF_BANK: prdata <= {24'h00_0000, bank_reg};
					mfr_pkg::OFF_OPTION: prdata <= {31'h0, enh_reg};
					mfr_pkg::OFF_STATUS: prdata <= {30'h0, st_reg != mfr_pkg::ST_IDLE, cont_reg};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence enter_mode;
		addr_done && !cs_rise && dual_reg && enh_reg;
	endsequence
	sequence first_fall;
		sck_fall && !cs_rise && st_reg == mfr_pkg::ST_WAIT && wait_reg == 5'h00;
	endsequence
	sequence byte_start;
		data_fall && slot_reg == 2'h0;
	endsequence

	narrow_quad_a: assert property (instr_last && !cs_rise && op == mfr_pkg::CMD_QUAD_RD && quad_en
		&& !bank_reg[mfr_pkg::BANK_EXT_BIT] |=> cnt_reg == 6'h18 && !dual_reg)
		else $error("quad read address length wrong");
	wide_quad_a: assert property (instr_last && !cs_rise && op == mfr_pkg::CMD_QUAD_RD_WIDE && quad_en
		|=> cnt_reg == 6'h20 && wide_reg) else $error("wide quad read length wrong");
	quad_gate_a: assert property (instr_last && !cs_rise && dec == 3'b100 && !quad_en
		|=> st_reg == mfr_pkg::ST_SKIP) else $error("quad read ran while disabled");
	ext_dual_a: assert property (instr_last && !cs_rise && op == mfr_pkg::CMD_DUAL_RD
		&& bank_reg[mfr_pkg::BANK_EXT_BIT] |=> cnt_reg == 6'h20 && dual_reg)
		else $error("dual read ignores extended mode");
	wide_dual_a: assert property (instr_last && !cs_rise && op == mfr_pkg::CMD_DUAL_RD_WIDE
		|=> wide_reg && dual_reg && st_reg == mfr_pkg::ST_ADDR) else $error("wide dual wrong");
	base_nomode_a: assert property (addr_done && !cs_rise && !enh_reg
		|=> st_reg == mfr_pkg::ST_WAIT && wait_reg == $past(dummy_sel))
		else $error("dummy load wrong");
	mode_cycles_a: assert property (enter_mode |=> st_reg == mfr_pkg::ST_MODE && cnt_reg == 6'h08)
		else $error("mode phase not entered");
	zero_dummy_a: assert property (first_fall |=> st_reg == mfr_pkg::ST_DATA && io_oe_n != 4'hF)
		else $error("data not driven after dummies");
	quad_nibble_a: assert property (byte_start and !dual_reg
		|=> io_out == $past(mem_rdata[7:4]) && io_oe_n == 4'h0)
		else $error("quad nibble wrong");
	dual_pair_a: assert property (byte_start and dual_reg
		|=> io_out[1:0] == $past(mem_rdata[7:6]) && io_oe_n == 4'b1100)
		else $error("dual pair wrong");
	addr_step_a: assert property (byte_start |=> mem_addr == $past(mem_addr) + 1'b1)
		else $error("address not stepped");
	addr_wrap_a: assert property (byte_start and (&mem_addr) |=> mem_addr == '0)
		else $error("address did not wrap");
	bank_bits_a: assert property (addr_done && !cs_rise && !wide_reg
		|=> mem_addr[ADDR_W-1:24] == $past(bank_reg[ADDR_W-25:0]))
		else $error("bank bits not used");
	mode_keep_a: assert property (cs_rise && mode_seen_reg && mode_ok_reg |=> cont_reg)
		else $error("continuous mode lost");
	mode_capture_a: assert property (mode_done && !cs_rise |=> mode_seen_reg &&
		(mode_ok_reg == (sh_reg[7:4] == 4'hA))) else $error("mode nibble misjudged");
	cont_start_a: assert property (cs_fall && cont_reg |=> st_reg == mfr_pkg::ST_ADDR && dual_reg)
		else $error("continuous frame not at address");
	mode_drop_a: assert property (cs_rise && mode_seen_reg && !mode_ok_reg |=> !cont_reg)
		else $error("continuous mode kept");
	short_drop_a: assert property (cs_rise && !mode_seen_reg && rise_reg <= 4'h8 |=> !cont_reg)
		else $error("short frame kept continuous mode");
	release_a: assert property (cs_rise |=> (io_oe_n == 4'hF) [*2])
		else $error("lines driven after select rise");
endmodule

// File: dv/mfr_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host memory controller and the shared io wire
module mfr_host_model (
	// system
	input wire logic clk,
	// pins toward the device
	output logic spi_cs_n,
	output logic spi_sck,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	logic [3:0] host_io;

	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		host_io = 4'h0;
	end

	// device level wins only on lanes it enables
	assign io_in = (io_out & ~io_oe_n) | (host_io & io_oe_n);

	// ==========================================
	// framing; select only rises during data or before any mode bit
	task automatic begin_frame();
		@(posedge clk);
		spi_cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic end_frame();
		repeat (4) @(posedge clk);
		spi_cs_n <= 1'b1;
		host_io <= ~host_io;
		repeat (8) @(posedge clk);
	endtask

	// ==========================================
	// one rise per step, msb first; samples the wire just before the fall
	task automatic shift(input logic [31:0] val, input int nbits, input int lanes,
		input bit drive, output logic [31:0] got, output bit oe_ok);
		logic [3:0] mask;
		logic [3:0] lv;
		int i;
		mask = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
		got = 32'h0000_0000;
		oe_ok = 1'b1;
		for (i = 0; i < nbits / lanes; i++) begin
			lv = 4'(val >> (nbits - lanes * (i + 1))) & mask;
			// released lanes flip each cycle so a stale level never looks valid
			host_io <= drive ? ((~host_io & ~mask) | lv) : ~host_io;
			repeat (4) @(posedge clk);
			spi_sck <= 1'b1;
			repeat (4) @(posedge clk);
			got = (got << lanes) | 32'(io_in & mask);
			if ((io_oe_n & mask) !== 4'h0) oe_ok = 1'b0;
			spi_sck <= 1'b0;
		end
	endtask
endmodule

// File: dv/mfr_read_engine_bench.sv
`timescale 1ns/1ps
module mfr_read_engine_bench;
	localparam int ADDR_W = 25;
	localparam logic [39:0] QMAP = {8{5'h02}};
	localparam logic [39:0] DMAP = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic spi_cs_n;
	logic spi_sck;
	logic [3:0] io_in;
	logic [3:0] io_out;
	logic [3:0] io_oe_n;
	logic [ADDR_W-1:0] mem_addr;
	logic [7:0] mem_rdata = 8'h00;
	int miscompares = 0;
	int samples_checked = 0;
	integer seed = 32'h0000_18c1;
	logic quiet = 1'b0;
	logic seen_drive = 1'b0;
	logic [31:0] rd;
	logic [31:0] a;
	logic [31:0] g;
	logic err;
	bit k;
	int lc;

	always #2 clk = ~clk;

	mfr_read_engine #(.ADDR_W(ADDR_W), .QUAD_DUMMY_MAP(QMAP), .DUAL_DUMMY_MAP(DMAP)) u_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

	mfr_host_model u_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n));

	// ==========================================
	// array model and reference
	function automatic logic [7:0] mem_fn(input logic [ADDR_W-1:0] ad);
		return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ {7'h00, ad[24]};
	endfunction

	always @(posedge clk) mem_rdata <= mem_fn(mem_addr);
	always @(posedge clk) if (quiet && io_oe_n !== 4'hF) seen_drive <= 1'b1;

	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task stop_test();
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ==========================================
	// apb master: holds the request until pready is seen high
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			miscompares++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task status_is(input logic e);
		apb(1'b0, mfr_pkg::OFF_STATUS, 32'h0000_0000);
		check(rd, 32'(e));
	endtask

	// ==========================================
	// one read frame against the reference byte stream
	task run_read(input logic [7:0] cmd, input bit instr, input logic [31:0] ad, input int abits,
		input int alanes, input bit mode_en, input logic [7:0] mode, input int dum, input int dl,
		input int nb, input logic [ADDR_W-1:0] eff);
		logic [31:0] expv;
		int b;
		expv = 32'h0000_0000;
		for (b = 0; b < nb; b++) expv = (expv << 8) | 32'(mem_fn(eff + ADDR_W'(b)));
		u_host.begin_frame();
		if (instr) u_host.shift(32'(cmd), 8, 1, 1'b1, g, k);
		u_host.shift(ad, abits, alanes, 1'b1, g, k);
		if (mode_en) u_host.shift(32'(mode), 8, 2, 1'b1, g, k);
		u_host.shift(32'h0000_0000, dum, 1, 1'b0, g, k);
		u_host.shift(32'h0000_0000, nb * 8, dl, 1'b0, g, k);
		check(g, expv);
		check(32'(k), 32'h0000_0001);
		u_host.end_frame();
		check(32'(io_oe_n), 32'h0000_000F);
	endtask

	initial begin
		#300000;
		miscompares++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			check(rd, 32'h0000_0000);
			check(32'(err), 32'h0000_0000);
		end
		apb(1'b0, 8'h10, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		seen_drive = 1'b0;
		quiet = 1'b1;
		u_host.begin_frame();
		u_host.shift(32'(mfr_pkg::CMD_QUAD_RD), 8, 1, 1'b1, g, k);
		u_host.shift(32'h0012_3456, 24, 1, 1'b1, g, k);
		u_host.shift(32'h0000_0000, 24, 4, 1'b0, g, k);
		u_host.end_frame();
		quiet = 1'b0;
		check(32'(seen_drive), 32'h0000_0000);
		apb(1'b1, mfr_pkg::OFF_CONFIG, 32'h0000_0002);
		apb(1'b0, mfr_pkg::OFF_CONFIG, 32'h0000_0000);
		check(rd, 32'h0000_0002);
		a = $random(seed);
		run_read(mfr_pkg::CMD_QUAD_RD, 1, {8'h00, a[23:0]}, 24, 1, 0, 8'h00, int'(QMAP[4:0]),
			4, 4, {1'b0, a[23:0]});
		run_read(mfr_pkg::CMD_QUAD_RD_WIDE, 1, 32'h01FF_FFFE, 32, 1, 0, 8'h00, int'(QMAP[4:0]),
			4, 4, 25'h1FF_FFFE);
		apb(1'b1, mfr_pkg::OFF_BANK, 32'h0000_0080);
		a = $random(seed);
		run_read(mfr_pkg::CMD_QUAD_RD, 1, a, 32, 1, 0, 8'h00, 2, 4, 2, a[24:0]);
		run_read(mfr_pkg::CMD_DUAL_RD, 1, a, 32, 2, 0, 8'h00, 0, 2, 2, a[24:0]);
		apb(1'b1, mfr_pkg::OFF_BANK, 32'h0000_0001);
		run_read(mfr_pkg::CMD_DUAL_RD, 1, {8'h00, a[23:0]}, 24, 2, 0, 8'h00, 0, 2, 2,
			{1'b1, a[23:0]});
		run_read(mfr_pkg::CMD_DUAL_RD_WIDE, 1, a, 32, 2, 0, 8'h00, 0, 2, 2, a[24:0]);
		for (lc = 0; lc < 4; lc++) begin
			apb(1'b1, mfr_pkg::OFF_CONFIG, 32'(lc << 6) | 32'h0000_0002);
			a = $random(seed);
			run_read(mfr_pkg::CMD_DUAL_RD, 1, {8'h00, a[23:0]}, 24, 2, 0, 8'h00,
				int'(DMAP[lc * 5 +: 5]), 2, 3, {1'b1, a[23:0]});
		end
		apb(1'b1, mfr_pkg::OFF_BANK, 32'h0000_0000);
		apb(1'b1, mfr_pkg::OFF_OPTION, 32'h0000_0001);
		run_read(mfr_pkg::CMD_DUAL_RD, 1, {8'h00, a[23:0]}, 24, 2, 1, 8'hA5,
			int'(DMAP[35 +: 5]), 2, 2, {1'b0, a[23:0]});
		status_is(1'b1);
		a = $random(seed);
		run_read(8'h00, 0, {8'h00, a[23:0]}, 24, 2, 1, 8'hA3, int'(DMAP[35 +: 5]), 2, 2,
			{1'b0, a[23:0]});
		status_is(1'b1);
		run_read(8'h00, 0, {8'h00, a[23:0]}, 24, 2, 1, 8'h5A, int'(DMAP[35 +: 5]), 2, 2,
			{1'b0, a[23:0]});
		status_is(1'b0);
		run_read(mfr_pkg::CMD_DUAL_RD, 1, {8'h00, a[23:0]}, 24, 2, 1, 8'hAF,
			int'(DMAP[35 +: 5]), 2, 2, {1'b0, a[23:0]});
		status_is(1'b1);
		u_host.begin_frame();
		u_host.shift(32'h0000_00FF, 4, 1, 1'b1, g, k);
		u_host.end_frame();
		status_is(1'b0);
		stop_test();
	end
endmodule
